// file: inc/dpmb_pkg.sv
// ==========================================================================
// mailbox package: addresses, csr layout, timing and carriers
package dpmb_pkg;

    // ======================================================================
    // internal cpu addresses
    localparam logic [11:0] DPMB_ADDR_HI = 12'hFFF;
    localparam logic [15:0] DPMB_CSR_ADDR = 16'hFFF0;
    localparam logic [15:0] DPMB_FIRST_ADDR = 16'hFFF1;
    localparam logic [15:0] DPMB_BYTE01_ADDR = 16'hFFF2;
    localparam logic [15:0] DPMB_LAST_ADDR = 16'hFFFF;

    // ======================================================================
    // location selects, shared by cpu low nibble and master select pins
    localparam logic [3:0] DPMB_SEL_CSR = 4'h0;
    localparam logic [3:0] DPMB_SEL_FIRST = 4'h1;
    localparam logic [3:0] DPMB_SEL_BYTE01 = 4'h2;
    localparam logic [3:0] DPMB_SEL_LAST = 4'hF;

    // ======================================================================
    // control/status field positions and reset value
    localparam int DPMB_MW_DONE_BIT = 7;
    localparam int DPMB_MW_IRQ_EN_BIT = 6;
    localparam int DPMB_SW_DONE_BIT = 5;
    localparam int DPMB_HANDOFF_EN_BIT = 4;
    localparam int DPMB_MR_DONE_BIT = 3;
    localparam int DPMB_MR_IRQ_EN_BIT = 2;
    localparam int DPMB_MW_MODE_BIT = 1;
    localparam int DPMB_SW_MODE_BIT = 0;
    localparam logic [7:0] DPMB_CSR_RESET = 8'h00;
    localparam logic [7:0] DPMB_CPU_WMASK = 8'h54;
    localparam logic [7:0] DPMB_MST_WMASK = 8'h10;

    // ======================================================================
    // timing: bus states per internal cpu byte access
    localparam int DPMB_ACCESS_STATES = 3;
    localparam logic [1:0] DPMB_WAIT_STATES = 2'(DPMB_ACCESS_STATES - 2);

    // ======================================================================
    // internal access sequencer, gray along the path except done back to idle
    typedef enum logic [1:0] {
        DPMB_IDLE = 2'b00,
        DPMB_WAIT = 2'b01,
        DPMB_DONE = 2'b11
    } dpmb_state_e;

    // control/status register fields, msb first
    typedef struct packed {
        logic mw_done;
        logic mw_irq_en;
        logic sw_done;
        logic handoff_en;
        logic mr_done;
        logic mr_irq_en;
        logic mw_mode;
        logic sw_mode;
    } dpmb_csr_s;

    // one access: read or write, location and data
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] sel;
        logic [7:0] data;
    } dpmb_acc_s;

endpackage

// file: rtl/dpmb_top.sv
`timescale 1ns/100ps
`default_nettype none

module dpmb_top (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic SINGLE_CHIP_MODE,
    input wire logic MAILBOX_ENABLE,
    input wire logic STANDBY,
    input wire logic CPU_REQ,
    input wire logic CPU_WE,
    input wire logic [15:0] CPU_ADDR,
    input wire logic [7:0] CPU_WDATA,
    output logic CPU_ACK,
    output logic [7:0] CPU_RDATA,
    output logic MASTER_WRITE_DONE_IRQ,
    output logic MASTER_READ_DONE_IRQ,
    input wire logic MASTER_CS_N,
    input wire logic MASTER_WE_N,
    input wire logic MASTER_OE_N,
    input wire logic [3:0] MASTER_REG_SELECT,
    input wire logic [7:0] MASTER_DATA_BUS_IN,
    output logic [7:0] MASTER_DATA_BUS_OUT,
    output logic MASTER_DATA_BUS_OE,
    output logic HANDOFF_N,
    output logic HANDOFF_N_OE
);
    import dpmb_pkg::*;

    // ======================================================================
    // master pin synchronisers
    logic [14:0] pin_s1_reg, pin_s1_next;
    logic [14:0] pin_s2_reg, pin_s2_next;
    logic [14:0] pin_s3_reg, pin_s3_next;
    logic slave_mode;
    logic cs_n2, we_n2, oe_n2, cs_n3, we_n3, oe_n3;
    dpmb_acc_s mst_acc;

    // slave mode needs single-chip operation and the mailbox enabled
    assign slave_mode = SINGLE_CHIP_MODE & MAILBOX_ENABLE;

    // pins pass two flops; the third stage feeds edge detection and the master access select and data
    always_comb begin
        pin_s1_next = {MASTER_CS_N, MASTER_WE_N, MASTER_OE_N,
                       MASTER_REG_SELECT, MASTER_DATA_BUS_IN};
        pin_s2_next = pin_s1_reg;
        pin_s3_next = pin_s2_reg;
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pin_s1_reg <= 15'h7000;
            pin_s2_reg <= 15'h7000;
            pin_s3_reg <= 15'h7000;
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            pin_s3_reg <= pin_s3_next;
        end
    end

    assign cs_n2 = pin_s2_reg[14];
    assign we_n2 = pin_s2_reg[13];
    assign oe_n2 = pin_s2_reg[12];
    assign cs_n3 = pin_s3_reg[14];
    assign we_n3 = pin_s3_reg[13];
    assign oe_n3 = pin_s3_reg[12];

    // master access completes at the strobe's rising edge under select
    always_comb begin
        mst_acc.wr = slave_mode & ~cs_n3 & ~we_n3 & we_n2;
        mst_acc.rd = slave_mode & ~cs_n3 & ~oe_n3 & oe_n2;
        mst_acc.sel = pin_s3_reg[11:8];
        mst_acc.data = pin_s3_reg[7:0];
    end

    // ======================================================================
    // internal cpu access sequencer, three states per byte
    dpmb_state_e state_reg, state_next;
    dpmb_acc_s cpu_hold_reg, cpu_hold_next;
    dpmb_acc_s cpu_acc;
    logic cpu_hit;

    assign cpu_hit = (CPU_ADDR[15:4] == DPMB_ADDR_HI);

    // take request in idle, wait one state, finish in the third
    always_comb begin
        state_next = state_reg;
        cpu_hold_next = cpu_hold_reg;
        case (state_reg)
            DPMB_IDLE: begin
                if (CPU_REQ && cpu_hit) begin
                    state_next = DPMB_WAIT;
                    cpu_hold_next.rd = ~CPU_WE;
                    cpu_hold_next.wr = CPU_WE;
                    cpu_hold_next.sel = CPU_ADDR[3:0];
                    cpu_hold_next.data = CPU_WDATA;
                end
            end
            DPMB_WAIT: begin
                state_next = DPMB_DONE;
            end
            DPMB_DONE: begin
                state_next = DPMB_IDLE;
            end
            default: begin
                state_next = DPMB_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_reg <= DPMB_IDLE;
            cpu_hold_reg <= '0;
        end else begin
            state_reg <= state_next;
            cpu_hold_reg <= cpu_hold_next;
        end
    end

    // access takes effect in the final state
    always_comb begin
        cpu_acc = cpu_hold_reg;
        cpu_acc.rd = cpu_hold_reg.rd & (state_reg == DPMB_DONE);
        cpu_acc.wr = cpu_hold_reg.wr & (state_reg == DPMB_DONE);
    end

    assign CPU_ACK = (state_reg == DPMB_DONE);

    // ======================================================================
    // shared bytes and the split first byte
    logic [7:0] mem_reg [2:15];
    logic [7:0] mem_next [2:15];
    logic [7:0] cpu_first_reg, cpu_first_next;
    logic [7:0] mst_first_reg, mst_first_next;
    dpmb_csr_s csr_reg, csr_next;

    // first byte has one register per writer; data bytes are guarded
    always_comb begin
        mem_next = mem_reg;
        cpu_first_next = cpu_first_reg;
        mst_first_next = mst_first_reg;
        if (cpu_acc.wr && cpu_acc.sel == DPMB_SEL_FIRST) begin
            cpu_first_next = cpu_acc.data;
        end
        if (mst_acc.wr && mst_acc.sel == DPMB_SEL_FIRST) begin
            mst_first_next = mst_acc.data;
        end
        for (int i = 2; i <= 15; i++) begin
            if (cpu_acc.wr && cpu_acc.sel == 4'(i) && !csr_reg.mw_mode) begin
                mem_next[i] = cpu_acc.data;
            end
            if (mst_acc.wr && mst_acc.sel == 4'(i) && !csr_reg.sw_mode) begin
                mem_next[i] = mst_acc.data;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            for (int i = 2; i <= 15; i++) begin
                mem_reg[i] <= 8'h00;
            end
            cpu_first_reg <= 8'h00;
            mst_first_reg <= 8'h00;
        end else begin
            mem_reg <= mem_next;
            cpu_first_reg <= cpu_first_next;
            mst_first_reg <= mst_first_next;
        end
    end

    // ======================================================================
    // control/status flags, handoff pin and interrupt requests
    logic handoff_n_reg, handoff_n_next;
    logic mw_irq_reg, mw_irq_next;
    logic mr_irq_reg, mr_irq_next;
    logic cpu_rd_first, cpu_wr_first, cpu_rd_last, cpu_wr_last;
    logic mst_rd_first, mst_wr_first, mst_rd_last, mst_wr_last;
    logic mst_rd_csr, pin_low_ev, pin_high_ev;

    // first and last byte accesses and master csr reads drive the protocol
    assign cpu_rd_first = cpu_acc.rd & (cpu_acc.sel == DPMB_SEL_FIRST);
    assign cpu_wr_first = cpu_acc.wr & (cpu_acc.sel == DPMB_SEL_FIRST);
    assign cpu_rd_last = cpu_acc.rd & (cpu_acc.sel == DPMB_SEL_LAST);
    assign cpu_wr_last = cpu_acc.wr & (cpu_acc.sel == DPMB_SEL_LAST);
    assign mst_rd_first = mst_acc.rd & (mst_acc.sel == DPMB_SEL_FIRST);
    assign mst_wr_first = mst_acc.wr & (mst_acc.sel == DPMB_SEL_FIRST);
    assign mst_rd_last = mst_acc.rd & (mst_acc.sel == DPMB_SEL_LAST);
    assign mst_wr_last = mst_acc.wr & (mst_acc.sel == DPMB_SEL_LAST);
    assign mst_rd_csr = mst_acc.rd & (mst_acc.sel == DPMB_SEL_CSR);

    // pin events; low takes priority when both land together
    assign pin_low_ev = (cpu_rd_first & csr_reg.mw_mode) | cpu_wr_last;
    assign pin_high_ev = mst_rd_last | mst_rd_csr | mst_wr_first
                         | cpu_wr_first;

    // flags: a set wins over a clear in the same cycle, except standby, whose clear wins
    always_comb begin
        csr_next = csr_reg;
        handoff_n_next = handoff_n_reg;
        if (cpu_acc.wr && cpu_acc.sel == DPMB_SEL_CSR) begin
            csr_next.mw_irq_en = cpu_acc.data[DPMB_MW_IRQ_EN_BIT];
            csr_next.handoff_en = cpu_acc.data[DPMB_HANDOFF_EN_BIT];
            csr_next.mr_irq_en = cpu_acc.data[DPMB_MR_IRQ_EN_BIT];
        end
        if (mst_acc.wr && mst_acc.sel == DPMB_SEL_CSR) begin
            csr_next.handoff_en = mst_acc.data[DPMB_HANDOFF_EN_BIT];
        end
        if (cpu_rd_last) begin
            csr_next.mw_done = 1'b0;
        end
        if (mst_wr_last) begin
            csr_next.mw_done = 1'b1;
        end
        if (mst_rd_last) begin
            csr_next.sw_done = 1'b0;
        end
        if (cpu_wr_last) begin
            csr_next.sw_done = 1'b1;
        end
        if (cpu_rd_first || cpu_wr_first || mst_wr_first) begin
            csr_next.mr_done = 1'b0;
        end
        if (mst_rd_first) begin
            csr_next.mr_done = 1'b1;
        end
        if (cpu_rd_first) begin
            csr_next.mw_mode = 1'b0;
        end
        if (mst_wr_first && !csr_reg.sw_mode) begin
            csr_next.mw_mode = 1'b1;
        end
        if (mst_rd_first) begin
            csr_next.sw_mode = 1'b0;
        end
        if (cpu_wr_first && !csr_reg.mw_mode && !mst_wr_first) begin
            csr_next.sw_mode = 1'b1;
        end
        if (csr_reg.handoff_en && pin_high_ev) begin
            handoff_n_next = 1'b1;
        end
        if (csr_reg.handoff_en && pin_low_ev) begin
            handoff_n_next = 1'b0;
        end
        if (STANDBY) begin
            csr_next = DPMB_CSR_RESET;
            handoff_n_next = 1'b1;
        end
    end

    // interrupt requests follow the flags through their enables
    always_comb begin
        mw_irq_next = csr_next.mw_done & csr_next.mw_irq_en;
        mr_irq_next = csr_next.mr_done & csr_next.mr_irq_en;
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            csr_reg <= DPMB_CSR_RESET;
            handoff_n_reg <= 1'b1;
            mw_irq_reg <= 1'b0;
            mr_irq_reg <= 1'b0;
        end else begin
            csr_reg <= csr_next;
            handoff_n_reg <= handoff_n_next;
            mw_irq_reg <= mw_irq_next;
            mr_irq_reg <= mr_irq_next;
        end
    end

    assign MASTER_WRITE_DONE_IRQ = mw_irq_reg;
    assign MASTER_READ_DONE_IRQ = mr_irq_reg;
    assign HANDOFF_N = handoff_n_reg;
    assign HANDOFF_N_OE = slave_mode & csr_reg.handoff_en;

    // ======================================================================
    // read data for both sides
    logic [7:0] cpu_rdata_reg, cpu_rdata_next;
    logic [7:0] mst_rdata_reg, mst_rdata_next;
    logic [3:0] mst_sel_now;

    assign mst_sel_now = pin_s2_reg[11:8];

    // cpu sees the master's first byte; master sees the cpu's
    always_comb begin
        cpu_rdata_next = cpu_rdata_reg;
        mst_rdata_next = mst_rdata_reg;
        if (cpu_acc.rd) begin
            if (cpu_acc.sel == DPMB_SEL_CSR) begin
                cpu_rdata_next = csr_reg;
            end else if (cpu_acc.sel == DPMB_SEL_FIRST) begin
                cpu_rdata_next = mst_first_reg;
            end else begin
                cpu_rdata_next = mem_reg[cpu_acc.sel];
            end
        end
        if (slave_mode && !cs_n2 && !oe_n2) begin
            if (mst_sel_now == DPMB_SEL_CSR) begin
                mst_rdata_next = csr_reg;
            end else if (mst_sel_now == DPMB_SEL_FIRST) begin
                mst_rdata_next = cpu_first_reg;
            end else begin
                mst_rdata_next = mem_reg[mst_sel_now];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            cpu_rdata_reg <= 8'h00;
            mst_rdata_reg <= 8'h00;
        end else begin
            cpu_rdata_reg <= cpu_rdata_next;
            mst_rdata_reg <= mst_rdata_next;
        end
    end

    assign CPU_RDATA = cpu_rdata_reg;
    assign MASTER_DATA_BUS_OUT = mst_rdata_reg;
    assign MASTER_DATA_BUS_OE = slave_mode & ~cs_n2 & ~oe_n2;

    // ======================================================================
    // checks
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    sequence cpu_take_s;
        state_reg == DPMB_IDLE && CPU_REQ && cpu_hit;
    endsequence
    sequence cpu_finish_s;
        !CPU_ACK ##1 CPU_ACK ##1 !CPU_ACK;
    endsequence

    three_state_a: assert property (cpu_take_s |=> cpu_finish_s)
        else $error("cpu access did not take three states");
    csr_clear_a: assert property (STANDBY |=> csr_reg == 8'h00)
        else $error("standby did not clear control status");
    mw_done_a: assert property (
        mst_wr_last && !STANDBY |=> csr_reg.mw_done)
        else $error("master last write did not set write done");
    mw_irq_a: assert property (
        MASTER_WRITE_DONE_IRQ == (csr_reg.mw_done && csr_reg.mw_irq_en))
        else $error("write done irq does not follow flag and enable");
    sw_done_a: assert property (
        cpu_wr_last && !STANDBY
        |=> csr_reg.sw_done ##0 (!HANDOFF_N_OE || !HANDOFF_N))
        else $error("cpu last write missed flag or pin low");
    pin_float_a: assert property (
        !slave_mode || !csr_reg.handoff_en |-> !HANDOFF_N_OE)
        else $error("handoff pin driven while disabled");
    pin_high_a: assert property (
        csr_reg.handoff_en && mst_rd_csr && !pin_low_ev && !STANDBY
        |=> HANDOFF_N)
        else $error("master status read did not release pin");
    mr_done_a: assert property (
        mst_rd_first && !cpu_wr_first && !STANDBY
        |=> csr_reg.mr_done && !csr_reg.sw_mode)
        else $error("master first read missed read done");
    mw_mode_a: assert property (
        mst_wr_first && !csr_reg.sw_mode && !STANDBY |=> csr_reg.mw_mode)
        else $error("master first write did not enter master mode");
    cpu_block_a: assert property (
        csr_reg.mw_mode && cpu_acc.wr && cpu_acc.sel == DPMB_SEL_BYTE01
        && !mst_acc.wr |=> $stable(mem_reg[2]))
        else $error("cpu wrote a byte during master mode");
    mst_block_a: assert property (
        csr_reg.sw_mode && mst_acc.wr && mst_acc.sel == DPMB_SEL_BYTE01
        && !cpu_acc.wr |=> $stable(mem_reg[2]))
        else $error("master wrote a byte during slave mode");
    mst_gate_a: assert property (
        !slave_mode |-> !mst_acc.wr && !mst_acc.rd && !MASTER_DATA_BUS_OE)
        else $error("master access outside slave mode");
endmodule

`default_nettype wire

// file: verif/dpmb_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// master cpu on the parallel port, strobes on falling edges
module dpmb_master_model (
    input wire logic clk,
    output logic cs_n,
    output logic we_n,
    output logic oe_n,
    output logic [3:0] sel,
    output logic [7:0] dout,
    input wire logic [7:0] bus
);
    // idle pins: not selected, strobes high
    initial begin
        cs_n = 1'b1;
        we_n = 1'b1;
        oe_n = 1'b1;
        sel = 4'h0;
        dout = 8'h00;
    end
    // one write, select and data held well around the strobe
    task automatic mst_write(input logic [3:0] s, input logic [7:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        sel = s;
        dout = d;
        repeat (2) @(negedge clk);
        we_n = 1'b0;
        repeat (4) @(negedge clk);
        we_n = 1'b1;
        repeat (3) @(negedge clk);
        cs_n = 1'b1;
        dout = ~d; // released lines never show the old value
        repeat (4) @(negedge clk);
    endtask
    // one read, data taken late in the strobe
    task automatic mst_read(input logic [3:0] s, output logic [7:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        sel = s;
        repeat (2) @(negedge clk);
        oe_n = 1'b0;
        repeat (6) @(negedge clk);
        d = bus;
        oe_n = 1'b1;
        repeat (3) @(negedge clk);
        cs_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dpmb_pkg::*;
    logic clk_sys, nrst, scm, men, stby, req, we, ack_q;
    logic [15:0] addr;
    logic [7:0] wd, v;
    logic ack, irq_w, irq_r, doe, hnd, hnd_oe, cs_n, we_n, oe_n;
    logic [7:0] rdata, dout, mdo, mbus;
    logic [3:0] sel;
    logic [8:0] exp_q[$];
    logic [8:0] mon_e;
    logic [7:0] md[16];
    int bad_count = 0;
    int tests_run = 0;
    int seed = 42970;
    // ======================================================
    // clock, bus resolution and the two sides
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    assign mbus = doe ? dout : mdo;
    dpmb_top i_dut (.CLK_SYS(clk_sys), .NRST(nrst), .SINGLE_CHIP_MODE(scm),
        .MAILBOX_ENABLE(men), .STANDBY(stby), .CPU_REQ(req), .CPU_WE(we),
        .CPU_ADDR(addr), .CPU_WDATA(wd), .CPU_ACK(ack), .CPU_RDATA(rdata),
        .MASTER_WRITE_DONE_IRQ(irq_w), .MASTER_READ_DONE_IRQ(irq_r),
        .MASTER_CS_N(cs_n), .MASTER_WE_N(we_n), .MASTER_OE_N(oe_n),
        .MASTER_REG_SELECT(sel), .MASTER_DATA_BUS_IN(mbus),
        .MASTER_DATA_BUS_OUT(dout), .MASTER_DATA_BUS_OE(doe),
        .HANDOFF_N(hnd), .HANDOFF_N_OE(hnd_oe));
    dpmb_master_model i_mst (.clk(clk_sys), .cs_n(cs_n), .we_n(we_n),
        .oe_n(oe_n), .sel(sel), .dout(mdo), .bus(mbus));
    // ======================================================
    // compare, verdict and watchdog
    task automatic check(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    // one internal access; e[8] marks a read result to compare
    task automatic cpu(input logic w, input logic [3:0] s,
        input logic [7:0] d, input logic [8:0] e);
        int n;
        exp_q.push_back(e);
        @(negedge clk_sys);
        req = 1'b1;
        we = w;
        addr = {DPMB_ADDR_HI, s};
        wd = d;
        n = 0;
        while (ack !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        check("cpu_ack_delay", 8'(n), 8'(DPMB_ACCESS_STATES - 1));
        @(negedge clk_sys);
        req = 1'b0;
    endtask
    task automatic pin(input logic oe_x, input logic lv);
        @(negedge clk_sys);
        check("handoff_oe", {7'h00, hnd_oe}, {7'h00, oe_x});
        check("handoff_n", {7'h00, hnd}, {7'h00, lv});
    endtask
    // read results land the cycle after the acknowledge
    always @(negedge clk_sys) begin
        if (ack_q === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            if (mon_e[8]) check("cpu_rdata", rdata, mon_e[7:0]);
        end
        ack_q = ack;
    end
    // ======================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        {scm, men, stby, req, we} = 5'h00;
        addr = 16'h0000;
        wd = 8'h00;
        for (int i = 0; i < 16; i++) md[i] = 8'($random(seed));
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h100);
        pin(1'b0, 1'b1);
        scm = 1'b1;
        men = 1'b1;
        cpu(1'b1, DPMB_SEL_CSR, 8'hFF, 9'h000);
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h154);
        pin(1'b1, 1'b1);
        // master to internal cpu, first byte first, last byte last
        i_mst.mst_write(DPMB_SEL_FIRST, md[1]);
        i_mst.mst_read(DPMB_SEL_CSR, v);
        check("csr_master", v, 8'h56);
        for (int k = 2; k < 16; k++) i_mst.mst_write(4'(k), md[k]);
        check("mw_irq", {7'h00, irq_w}, 8'h01);
        cpu(1'b1, DPMB_SEL_BYTE01, ~md[2], 9'h000);
        cpu(1'b0, DPMB_SEL_LAST, 8'h00, {1'b1, md[15]});
        for (int k = 14; k > 1; k--) cpu(1'b0, 4'(k), 8'h00, {1'b1, md[k]});
        cpu(1'b0, DPMB_SEL_FIRST, 8'h00, {1'b1, md[1]});
        pin(1'b1, 1'b0);
        check("mw_irq", {7'h00, irq_w}, 8'h00);
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h154);
        // internal cpu to master
        cpu(1'b1, DPMB_SEL_FIRST, md[0], 9'h000);
        pin(1'b1, 1'b1);
        for (int k = 2; k < 16; k++) cpu(1'b1, 4'(k), ~md[k], 9'h000);
        pin(1'b1, 1'b0);
        i_mst.mst_write(DPMB_SEL_BYTE01, md[2]);
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h175);
        i_mst.mst_read(DPMB_SEL_LAST, v);
        check("mst_last", v, ~md[15]);
        pin(1'b1, 1'b1);
        for (int k = 14; k > 1; k--) begin
            i_mst.mst_read(4'(k), v);
            check("mst_byte", v, ~md[k]);
        end
        i_mst.mst_read(DPMB_SEL_FIRST, v);
        check("mst_first", v, md[0]);
        check("mr_irq", {7'h00, irq_r}, 8'h01);
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h15C);
        i_mst.mst_write(DPMB_SEL_CSR, 8'h00);
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h14C);
        pin(1'b0, 1'b1);
        cpu(1'b0, DPMB_SEL_FIRST, 8'h00, {1'b1, md[1]});
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h144);
        check("mr_irq", {7'h00, irq_r}, 8'h00);
        // outside slave mode: master ignored, bytes are plain memory
        cpu(1'b1, DPMB_SEL_CSR, 8'h10, 9'h000);
        men = 1'b0;
        pin(1'b0, 1'b1);
        i_mst.mst_write(4'h6, ~md[6] ^ 8'h5A);
        cpu(1'b0, 4'h6, 8'h00, {1'b1, ~md[6]});
        cpu(1'b1, 4'h7, 8'h3C, 9'h000);
        cpu(1'b0, 4'h7, 8'h00, 9'h13C);
        // standby clears the control/status register
        @(negedge clk_sys);
        stby = 1'b1;
        @(negedge clk_sys);
        stby = 1'b0;
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h100);
        // a reset in mid-run clears the control/status register again
        cpu(1'b1, DPMB_SEL_CSR, 8'hFF, 9'h000);
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h154);
        nrst = 1'b0;
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        cpu(1'b0, DPMB_SEL_CSR, 8'h00, 9'h100);
        repeat (2) @(negedge clk_sys);
        report_and_stop();
    end
endmodule
`default_nettype wire
